// ---- flash_host_pkg.sv ----
// constants shared by the parallel flash host controller and its bus cycle engine
// assumes a 200 MHz clock and a byte-wide asynchronous nor flash on the far side
package flash_host_pkg;

   // clock and pin timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int GLITCH_NS = 5;
   localparam int WE_PULSE_NS = 40;
   localparam int READ_ACCESS_NS = 70;
   localparam int WE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] WE_CNT_INIT = 5'(WE_CYC - 1);
   localparam logic [4:0] RD_CNT_INIT = 5'(RD_CYC - 1);

   // address layout
   localparam int ADDR_W = 20;
   localparam int CMD_ADDR_W = 15;
   localparam int SECTOR_LSB = 12;
   localparam int BLOCK_LSB = 16;
   localparam int TOGGLE_BIT = 6;
   localparam logic [CMD_ADDR_W-1:0] CMD_ADDR_A = 15'h0AAA;
   localparam logic [CMD_ADDR_W-1:0] CMD_ADDR_B = 15'h0555;

   // command data bytes
   localparam logic [7:0] DAT_UNLOCK1 = 8'hAA;
   localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
   localparam logic [7:0] DAT_PROGRAM = 8'hA0;
   localparam logic [7:0] DAT_ERASE_SETUP = 8'h80;
   localparam logic [7:0] DAT_SECTOR = 8'h50;
   localparam logic [7:0] DAT_BLOCK = 8'h30;
   localparam logic [7:0] DAT_CHIP = 8'h10;
   localparam logic [7:0] DAT_ID_ENTRY = 8'h90;
   localparam logic [7:0] DAT_ID_EXIT = 8'hF0;

   // sequence positions and lengths
   localparam logic [2:0] STEP_UNLOCK2 = 3'h1;
   localparam logic [2:0] STEP_CMD = 3'h2;
   localparam logic [2:0] STEP_FOURTH = 3'h3;
   localparam logic [2:0] STEP_FIFTH = 3'h4;
   localparam logic [2:0] STEP_FINAL = 3'h5;
   localparam logic [2:0] LEN_PROGRAM = 3'h4;
   localparam logic [2:0] LEN_ERASE = 3'h6;
   localparam logic [2:0] LEN_ID_ENTRY = 3'h3;
   localparam logic [2:0] LEN_SINGLE = 3'h1;

   // user commands
   typedef enum logic [2:0] {
      OP_READ,
      OP_PROGRAM,
      OP_SECTOR_ERASE,
      OP_BLOCK_ERASE,
      OP_CHIP_ERASE,
      OP_ID_ENTRY,
      OP_ID_EXIT
   } op_t;

endpackage

// ---- flash_bus_cycle.sv ----
// one asynchronous flash bus cycle, write or read, with fixed strobe widths
// assumes the caller pulses go_i only while ready_o is high
`timescale 1ns/1ps
module flash_bus_cycle (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // request from the sequencer
   input wire logic go_i,
   input wire logic wr_i,
   input wire logic [19:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic ready_o,
   output logic done_o,
   output logic [7:0] rdata_o,
   // flash pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [19:0] addr_o,
   output logic [7:0] dq_o,
   output logic dq_oe_o,
   input wire logic [7:0] dq_i
);

   typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_RECOV} eng_st_t;

   typedef struct packed {
      eng_st_t st;
      logic [4:0] cnt;
      logic wr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [19:0] addr;
      logic [7:0] dq;
      logic dq_oe;
      logic [7:0] rdata;
      logic done;
   } eng_t;

   eng_t cur_ff;
   eng_t nxt_cur;

   // next state of the cycle engine
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.done = 1'b0;
      unique case (cur_ff.st)
         E_IDLE: begin
            if (go_i) begin
               nxt_cur.wr = wr_i;
               nxt_cur.addr = addr_i;
               nxt_cur.dq = wdata_i;
               nxt_cur.ce_n = 1'b0;
               nxt_cur.dq_oe = wr_i; // never drive while a read gate may open
               nxt_cur.st = E_SETUP;
            end
         end
         E_SETUP: begin
            // address and chip select settle a cycle before the strobe
            if (cur_ff.wr) begin
               nxt_cur.we_n = 1'b0; // oe stays high, so the write is not inhibited
               nxt_cur.cnt = flash_host_pkg::WE_CNT_INIT; // far above the glitch limit
            end else begin
               nxt_cur.oe_n = 1'b0;
               nxt_cur.cnt = flash_host_pkg::RD_CNT_INIT;
            end
            nxt_cur.st = E_STROBE;
         end
         E_STROBE: begin
            if (cur_ff.cnt == 5'h00) begin
               // we rises before ce, so data is taken on the we edge
               nxt_cur.we_n = 1'b1;
               nxt_cur.oe_n = 1'b1;
               if (!cur_ff.wr) begin
                  nxt_cur.rdata = dq_i;
               end
               nxt_cur.st = E_RECOV;
            end else begin
               nxt_cur.cnt = cur_ff.cnt - 5'h01;
            end
         end
         E_RECOV: begin
            nxt_cur.ce_n = 1'b1;
            nxt_cur.dq_oe = 1'b0;
            nxt_cur.done = 1'b1;
            nxt_cur.st = E_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cur_ff <= '{st: E_IDLE, cnt: 5'h00, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                     addr: 20'h00000, dq: 8'h00, dq_oe: 1'b0, rdata: 8'h00, done: 1'b0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign ready_o = (cur_ff.st == E_IDLE);
   assign done_o = cur_ff.done;
   assign rdata_o = cur_ff.rdata;
   assign ce_n_o = cur_ff.ce_n;
   assign oe_n_o = cur_ff.oe_n;
   assign we_n_o = cur_ff.we_n;
   assign addr_o = cur_ff.addr;
   assign dq_o = cur_ff.dq;
   assign dq_oe_o = cur_ff.dq_oe;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_we_oe_excl;
      !(!cur_ff.we_n && !cur_ff.oe_n);
   endproperty
   a_we_oe_excl: assert property (p_we_oe_excl) else $error("we and oe low together");

   property p_we_in_ce;
      !cur_ff.we_n |-> !cur_ff.ce_n && cur_ff.dq_oe;
   endproperty
   a_we_in_ce: assert property (p_we_in_ce) else $error("we low outside chip select");

   property p_we_width;
      $fell(cur_ff.we_n) |-> !cur_ff.we_n [*8] ##1 cur_ff.we_n;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

   property p_rd_width;
      $fell(cur_ff.oe_n) |-> ##13 !cur_ff.oe_n ##1 cur_ff.oe_n;
   endproperty
   a_rd_width: assert property (p_rd_width) else $error("read gate width wrong");

   property p_no_drive_on_read;
      !cur_ff.oe_n |-> !cur_ff.dq_oe;
   endproperty
   a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus fight");

endmodule

// ---- flash_host_ctrl.sv ----
// host controller for an asynchronous byte-wide nor flash: command sequences and polling
// assumes one user request at a time on cmd_valid_i / cmd_ready_o; flash on the pins
// Summary of operation
// - poll only after the last sequence write
// - program: two unlocks and the program command, then target write
// - erase: six writes, final selects the kind
// - command addresses use low fifteen bits
`timescale 1ns/1ps
module flash_host_ctrl #(
   parameter int POLL_LIMIT = 2000000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // user command port
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_i,
   input wire logic [19:0] cmd_addr_i,
   input wire logic [7:0] cmd_data_i,
   output logic cmd_ready_o,
   // user status and read data
   output logic busy_o,
   output logic done_o,
   output logic timeout_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic id_mode_o,
   // flash pins
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   output logic [19:0] flash_addr_o,
   output logic [7:0] flash_dq_o,
   output logic flash_dq_oe_o,
   input wire logic [7:0] flash_dq_i
);

   typedef enum logic [2:0] {M_IDLE, M_ISSUE, M_WAIT, M_POLL, M_PWAIT} main_st_t;

   typedef struct packed {
      main_st_t st;
      flash_host_pkg::op_t op;
      logic [2:0] step;
      logic [19:0] addr;
      logic [7:0] data;
      logic prev_tog;
      logic have_prev;
      logic [31:0] polls;
      logic go;
      logic [19:0] eaddr;
      logic [7:0] edata;
      logic ewr;
      logic ready;
      logic busy;
      logic done;
      logic err;
      logic rd_valid;
      logic [7:0] rd_data;
      logic id_mode;
   } main_t;

   main_t cur_ff;
   main_t nxt_cur;
   logic eng_ready;
   logic eng_done;
   logic [7:0] eng_rdata;
   logic [27:0] word;
   logic [2:0] len;

   // number of bus writes each command needs
   function automatic logic [2:0] seq_len(input flash_host_pkg::op_t op);
      unique case (op)
         flash_host_pkg::OP_PROGRAM: seq_len = flash_host_pkg::LEN_PROGRAM;
         flash_host_pkg::OP_SECTOR_ERASE,
         flash_host_pkg::OP_BLOCK_ERASE,
         flash_host_pkg::OP_CHIP_ERASE: seq_len = flash_host_pkg::LEN_ERASE;
         flash_host_pkg::OP_ID_ENTRY: seq_len = flash_host_pkg::LEN_ID_ENTRY;
         default: seq_len = flash_host_pkg::LEN_SINGLE;
      endcase
   endfunction

   // address and data of one write in a sequence; upper command address bits driven low
   function automatic logic [27:0] seq_word(input flash_host_pkg::op_t op,
                                            input logic [2:0] step,
                                            input logic [19:0] a,
                                            input logic [7:0] d);
      logic [19:0] ca;
      logic [7:0] cd;
      ca = {{(flash_host_pkg::ADDR_W - flash_host_pkg::CMD_ADDR_W){1'b0}},
            flash_host_pkg::CMD_ADDR_A};
      cd = flash_host_pkg::DAT_UNLOCK1; // first write of every sequence except id exit
      unique case (step)
         flash_host_pkg::STEP_UNLOCK2,
         flash_host_pkg::STEP_FIFTH: begin
            ca = {{(flash_host_pkg::ADDR_W - flash_host_pkg::CMD_ADDR_W){1'b0}},
                  flash_host_pkg::CMD_ADDR_B};
            cd = flash_host_pkg::DAT_UNLOCK2;
         end
         flash_host_pkg::STEP_CMD: begin
            if (op == flash_host_pkg::OP_PROGRAM) begin
               cd = flash_host_pkg::DAT_PROGRAM;
            end else if (op == flash_host_pkg::OP_ID_ENTRY) begin
               cd = flash_host_pkg::DAT_ID_ENTRY;
            end else begin
               cd = flash_host_pkg::DAT_ERASE_SETUP;
            end
         end
         flash_host_pkg::STEP_FOURTH: begin
            if (op == flash_host_pkg::OP_PROGRAM) begin
               ca = a; // target byte after the unlocks
               cd = d;
            end
         end
         flash_host_pkg::STEP_FINAL: begin
            if (op == flash_host_pkg::OP_SECTOR_ERASE) begin
               ca = {a[flash_host_pkg::ADDR_W-1:flash_host_pkg::SECTOR_LSB],
                     {flash_host_pkg::SECTOR_LSB{1'b0}}};
               cd = flash_host_pkg::DAT_SECTOR;
            end else if (op == flash_host_pkg::OP_BLOCK_ERASE) begin
               ca = {a[flash_host_pkg::ADDR_W-1:flash_host_pkg::BLOCK_LSB],
                     {flash_host_pkg::BLOCK_LSB{1'b0}}};
               cd = flash_host_pkg::DAT_BLOCK;
            end else begin
               cd = flash_host_pkg::DAT_CHIP;
            end
         end
         default: begin
         end
      endcase
      if (op == flash_host_pkg::OP_ID_EXIT) begin
         ca = a;
         cd = flash_host_pkg::DAT_ID_EXIT; // single write, any address
      end else if (op == flash_host_pkg::OP_READ) begin
         ca = a;
      end
      seq_word = {ca, cd};
   endfunction

   assign word = seq_word(cur_ff.op, cur_ff.step, cur_ff.addr, cur_ff.data);
   assign len = seq_len(cur_ff.op);

   // sequencer; new commands are only taken in idle, which a poll timeout reaches while the flash may still be busy
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.go = 1'b0;
      nxt_cur.done = 1'b0;
      nxt_cur.rd_valid = 1'b0;
      unique case (cur_ff.st)
         M_IDLE: begin
            if (cmd_valid_i && cur_ff.ready) begin
               nxt_cur.op = flash_host_pkg::op_t'(cmd_i);
               nxt_cur.addr = cmd_addr_i;
               nxt_cur.data = cmd_data_i;
               nxt_cur.step = 3'h0;
               nxt_cur.err = 1'b0;
               nxt_cur.busy = 1'b1;
               nxt_cur.st = M_ISSUE;
            end
         end
         M_ISSUE: begin
            if (eng_ready) begin
               nxt_cur.go = 1'b1;
               nxt_cur.eaddr = word[27:8];
               nxt_cur.edata = word[7:0];
               nxt_cur.ewr = (cur_ff.op != flash_host_pkg::OP_READ);
               nxt_cur.st = M_WAIT;
            end
         end
         M_WAIT: begin
            if (eng_done) begin
               if (cur_ff.op == flash_host_pkg::OP_READ) begin
                  nxt_cur.rd_data = eng_rdata; // ident codes when in id mode
                  nxt_cur.rd_valid = 1'b1;
                  nxt_cur.done = 1'b1;
                  nxt_cur.busy = 1'b0;
                  nxt_cur.st = M_IDLE;
               end else if (cur_ff.step + 3'h1 != len) begin
                  nxt_cur.step = cur_ff.step + 3'h1;
                  nxt_cur.st = M_ISSUE;
               end else if (cur_ff.op == flash_host_pkg::OP_ID_ENTRY ||
                            cur_ff.op == flash_host_pkg::OP_ID_EXIT) begin
                  nxt_cur.id_mode = (cur_ff.op == flash_host_pkg::OP_ID_ENTRY);
                  nxt_cur.done = 1'b1;
                  nxt_cur.busy = 1'b0;
                  nxt_cur.st = M_IDLE;
               end else begin
                  // status is valid only after the last strobe has risen
                  nxt_cur.have_prev = 1'b0;
                  nxt_cur.polls = 32'h0000_0000;
                  nxt_cur.st = M_POLL;
               end
            end
         end
         M_POLL: begin
            if (eng_ready) begin
               nxt_cur.go = 1'b1;
               nxt_cur.eaddr = cur_ff.addr;
               nxt_cur.ewr = 1'b0;
               nxt_cur.st = M_PWAIT;
            end
         end
         M_PWAIT: begin
            if (eng_done) begin
               // only the toggle bit is trusted; bit seven is returned raw
               nxt_cur.rd_data = eng_rdata;
               nxt_cur.prev_tog = eng_rdata[flash_host_pkg::TOGGLE_BIT];
               nxt_cur.have_prev = 1'b1;
               nxt_cur.polls = cur_ff.polls + 32'h0000_0001;
               if (cur_ff.have_prev &&
                   eng_rdata[flash_host_pkg::TOGGLE_BIT] == cur_ff.prev_tog) begin
                  nxt_cur.done = 1'b1;
                  nxt_cur.busy = 1'b0;
                  nxt_cur.st = M_IDLE;
               end else if (cur_ff.polls == 32'(POLL_LIMIT)) begin
                  // a stuck flash must not hang the host forever
                  nxt_cur.err = 1'b1;
                  nxt_cur.done = 1'b1;
                  nxt_cur.busy = 1'b0;
                  nxt_cur.st = M_IDLE;
               end else begin
                  nxt_cur.st = M_POLL;
               end
            end
         end
         default: begin
            nxt_cur.st = M_IDLE;
         end
      endcase
      nxt_cur.ready = (nxt_cur.st == M_IDLE);
   end

   // state register; id mode clears at reset since the flash starts in read mode
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cur_ff <= '{st: M_IDLE, op: flash_host_pkg::OP_READ, step: 3'h0, addr: 20'h00000,
                     data: 8'h00, prev_tog: 1'b0, have_prev: 1'b0, polls: 32'h0000_0000,
                     go: 1'b0, eaddr: 20'h00000, edata: 8'h00, ewr: 1'b0, ready: 1'b1,
                     busy: 1'b0, done: 1'b0, err: 1'b0, rd_valid: 1'b0, rd_data: 8'h00,
                     id_mode: 1'b0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // pin timing lives in the cycle engine
   flash_bus_cycle u_cycle (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .go_i(cur_ff.go),
      .wr_i(cur_ff.ewr),
      .addr_i(cur_ff.eaddr),
      .wdata_i(cur_ff.edata),
      .ready_o(eng_ready),
      .done_o(eng_done),
      .rdata_o(eng_rdata),
      .ce_n_o(flash_ce_n_o),
      .oe_n_o(flash_oe_n_o),
      .we_n_o(flash_we_n_o),
      .addr_o(flash_addr_o),
      .dq_o(flash_dq_o),
      .dq_oe_o(flash_dq_oe_o),
      .dq_i(flash_dq_i)
   );

   assign cmd_ready_o = cur_ff.ready;
   assign busy_o = cur_ff.busy;
   assign done_o = cur_ff.done;
   assign timeout_o = cur_ff.err;
   assign rd_valid_o = cur_ff.rd_valid;
   assign rd_data_o = cur_ff.rd_data;
   assign id_mode_o = cur_ff.id_mode;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_first_unlock;
      $fell(flash_we_n_o) && cur_ff.step == 3'h0 && cur_ff.op != flash_host_pkg::OP_ID_EXIT
         |-> flash_addr_o == 20'h00AAA && flash_dq_o == 8'hAA;
   endproperty
   a_first_unlock: assert property (p_first_unlock) else $error("bad first unlock");

   property p_erase_setup;
      $fell(flash_we_n_o) && cur_ff.step == 3'h2 && cur_ff.op == flash_host_pkg::OP_CHIP_ERASE
         |-> flash_dq_o == 8'h80;
   endproperty
   a_erase_setup: assert property (p_erase_setup) else $error("bad erase setup");

   property p_sector_addr;
      $fell(flash_we_n_o) && cur_ff.step == 3'h5 && cur_ff.op == flash_host_pkg::OP_SECTOR_ERASE
         |-> flash_addr_o[11:0] == 12'h000 && flash_dq_o == 8'h50 &&
             flash_addr_o[19:12] == cur_ff.addr[19:12];
   endproperty
   a_sector_addr: assert property (p_sector_addr) else $error("bad sector write");

   property p_id_exit;
      $fell(flash_we_n_o) && cur_ff.op == flash_host_pkg::OP_ID_EXIT |-> flash_dq_o == 8'hF0;
   endproperty
   a_id_exit: assert property (p_id_exit) else $error("bad id exit byte");

   property p_ready_idle;
      cmd_ready_o |-> !busy_o && flash_we_n_o;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("ready while busy");

   property p_poll_no_write;
      cur_ff.st == M_POLL || cur_ff.st == M_PWAIT |-> flash_we_n_o;
   endproperty
   a_poll_no_write: assert property (p_poll_no_write) else $error("write during poll");

   property p_done_pulse;
      done_o |=> !done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");

   c_program: cover property (done_o && cur_ff.op == flash_host_pkg::OP_PROGRAM && !timeout_o);
   c_chip_erase: cover property (done_o && cur_ff.op == flash_host_pkg::OP_CHIP_ERASE);
   c_id_read: cover property (rd_valid_o && id_mode_o);
   c_timeout: cover property (timeout_o && done_o);

endmodule

// ---- flash_device_model.sv ----
// behavioural byte-wide flash: unlock tracker, toggle status, id mode and array
// assumes host pins come straight from the controller; events on pins only, no clock
`timescale 1ns/1ps
module flash_device_model #(
   parameter logic [7:0] MAKER_CODE = 8'h5C, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3E // arbitrary value
) (
   // host pins
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [19:0] addr_i,
   input wire logic [7:0] dq_i,
   input wire logic dq_oe_i,
   output logic [7:0] dq_o,
   // bench control and count of host misbehaviour
   input wire logic [7:0] busy_reads_i,
   output logic [15:0] violations_o = 16'h0000
);
   logic [7:0] mem [int];
   logic [19:0] a_lat, p_addr;
   logic [7:0] p_data, rd_q = 8'h00;
   logic id_mode = 1'b0; // starts in read mode
   logic tog = 1'b0;
   logic wr_open = 1'b0;
   logic rd_open = 1'b0;
   int step = 0;
   int busy = 0;
   int kind = 0;
   realtime t_fall;
   // released bus shows the inverse of the last value, never a stale copy
   assign dq_o = (!ce_n_i && !oe_n_i && we_n_i) ? rd_q : ~rd_q;
   // unlock tracker runs only while not busy; a mismatch drops back to idle
   task automatic cmd_write(input logic [19:0] a, input logic [7:0] d);
      logic [14:0] c;
      c = a[14:0];
      if (busy > 0) begin
         if (d != 8'hF0) violations_o++; // exit ignored while busy
      end else if (step == 6) begin
         kind = 1; // program target write
      end else if (d == 8'hF0) begin
         id_mode = 1'b0;
         step = 0;
      end else if (step == 2 && c == 15'h0AAA) begin
         id_mode = id_mode | (d == 8'h90);
         step = (d == 8'hA0) ? 6 : (d == 8'h80) ? 3 : 0;
      end else if (step == 5) begin
         kind = (d == 8'h50) ? 2 : (d == 8'h30) ? 3 : (c == 15'h0AAA && d == 8'h10) ? 4 : 0;
         step = 0;
      end else if ((step == 0 || step == 3) && c == 15'h0AAA && d == 8'hAA) begin
         step++;
      end else if ((step == 1 || step == 4) && c == 15'h0555 && d == 8'h55) begin
         step++;
      end else begin
         step = 0;
      end
      if (kind != 0 && busy == 0) begin
         // status is live from this rising strobe on
         p_addr = a;
         p_data = d;
         busy = busy_reads_i;
         step = 0;
      end
   endtask
   // each read access advances the status while busy
   task automatic read_access();
      begin
         if (dq_oe_i) violations_o++;
         if (busy > 0) begin
            tog = ~tog;
            rd_q = {(kind == 1) ? ~p_data[7] : 1'b0, tog, 6'h00};
            busy--;
            if (busy == 0 && kind == 1) begin
               mem[p_addr] = (mem.exists(p_addr) ? mem[p_addr] : 8'hFF) & p_data;
            end
            if (busy == 0 && kind > 1) begin
               foreach (mem[k]) begin
                  if (kind == 4 || (kind == 2 && k[19:12] == p_addr[19:12])
                      || (kind == 3 && k[19:16] == p_addr[19:16])) mem[k] = 8'hFF;
               end
            end
            if (busy == 0) kind = 0;
         end else if (id_mode && addr_i[19:1] == 19'h00000) begin
            rd_q = addr_i[0] ? PART_CODE : MAKER_CODE;
         end else begin
            rd_q = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
         end
      end
   endtask
   // one process owns all model state; the host moves one strobe per clock edge
   always @(we_n_i or ce_n_i or oe_n_i) begin
      if (!wr_open && !we_n_i && !ce_n_i && oe_n_i) begin
         a_lat = addr_i; // write opens at the later falling strobe
         t_fall = $realtime;
         wr_open = 1'b1;
      end else if (wr_open && (we_n_i || ce_n_i)) begin
         wr_open = 1'b0; // data at the first rising strobe
         if (!dq_oe_i || $realtime - t_fall < 5.0) violations_o++;
         else cmd_write(a_lat, dq_i);
      end
      if (!rd_open && !oe_n_i && !ce_n_i && we_n_i) begin
         rd_open = 1'b1;
         read_access();
      end else if (oe_n_i || ce_n_i) begin
         rd_open = 1'b0;
      end
   end
endmodule

// ---- flash_host_ctrl_bench.sv ----
// self-checking bench: host controller against the behavioural flash
// assumes flash_host_pkg, flash_host_ctrl and flash_device_model are compiled first
`timescale 1ns/1ps
module flash_host_ctrl_bench;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   logic [2:0] cmd_i = 3'h0;
   logic [19:0] cmd_addr_i = 20'h00000;
   logic [7:0] cmd_data_i = 8'h00;
   logic cmd_ready_o, busy_o, done_o, timeout_o, rd_valid_o, id_mode_o;
   logic ce_n, oe_n, we_n, dq_oe;
   logic [7:0] rd_data_o, dq_h, dq_f, rd, busy_reads = 8'h03;
   logic [19:0] fa, a;
   logic [15:0] viol;
   logic [7:0] sh [int];
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   int seed = 32'h367A1D13;
   // clock at 200 MHz
   always #2.5 clk_i = ~clk_i;
   flash_host_ctrl #(.POLL_LIMIT(20)) flash_host_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
      .cmd_ready_o(cmd_ready_o), .busy_o(busy_o), .done_o(done_o), .timeout_o(timeout_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .id_mode_o(id_mode_o),
      .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_addr_o(fa),
      .flash_dq_o(dq_h), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_f));
   flash_device_model flash_device_model_i (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .addr_i(fa), .dq_i(dq_h), .dq_oe_i(dq_oe), .dq_o(dq_f), .busy_reads_i(busy_reads),
      .violations_o(viol));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // expected read: id codes at addresses 0 and 1 in id mode, else shadow array, erased bytes read all ones
   function automatic logic [7:0] exp_rd(input logic [19:0] ra, input logic idm);
      if (idm && ra[19:1] == 19'h00000) return ra[0] ? 8'h3E : 8'h5C;
      return sh.exists(ra) ? sh[ra] : 8'hFF;
   endfunction
   task automatic erase_sh(input int k, input logic [19:0] ea);
      foreach (sh[x]) begin
         if (k == 4 || (k == 2 && x[19:12] == ea[19:12]) || (k == 3 && x[19:16] == ea[19:16]))
            sh[x] = 8'hFF;
      end
   endtask
   // one user command: raised at a falling edge seen ready, so the next rising edge takes it
   task automatic run(input logic [2:0] op, input logic [19:0] ca, input logic [7:0] cd);
      int n;
      n = 0;
      @(negedge clk_i);
      while (cmd_ready_o !== 1'b1 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      cmd_valid_i = 1'b1;
      cmd_i = op;
      cmd_addr_i = ca;
      cmd_data_i = cd;
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      chk("busy ready taken", 2'b10, {busy_o, cmd_ready_o});
      n = 0;
      while (done_o !== 1'b1 && n < 3000) begin
         @(negedge clk_i);
         n++;
      end
      chk("done", 1, done_o);
      chk("busy ready done", 2'b01, {busy_o, cmd_ready_o});
      rd = rd_data_o;
      if (op == 3'h0) chk("rd_valid", 1, rd_valid_o);
   endtask
   task automatic prog(input logic [19:0] pa, input logic [7:0] pd);
      run(flash_host_pkg::OP_PROGRAM, pa, pd);
      sh[pa] = exp_rd(pa, 1'b0) & pd;
      chk("timeout", 0, timeout_o);
   endtask
   task automatic rdchk(input logic [19:0] ra, input logic idm);
      run(flash_host_pkg::OP_READ, ra, 8'h00);
      chk("read", exp_rd(ra, idm), rd);
   endtask
   // hang guard: a run past the ceiling counts as a mismatch
   always @(posedge clk_i) begin
      cycles++;
      if (cycles >= 80000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      chk("ready", 1, cmd_ready_o);
      chk("pins", 3'h7, {ce_n, oe_n, we_n});
      // random programs, high address bits included, each read back
      for (int i = 0; i < 12; i++) begin
         a = 20'($random(seed));
         busy_reads = 8'h01 + 8'($random(seed) & 3);
         prog(a, 8'($random(seed)));
         rdchk(a, 1'b0);
      end
      // sector erase spares the neighbouring sector and block, block erase only the block, chip erase neither
      for (int k = 2; k <= 4; k++) begin
         a = 20'($random(seed));
         prog(a, 8'h00);
         prog(a ^ 20'h01000, 8'h00);
         prog(a ^ 20'h10000, 8'h00);
         run(3'(k), a, 8'h00);
         erase_sh(k, a);
         rdchk(a, 1'b0);
         rdchk(a ^ 20'h01000, 1'b0);
         rdchk(a ^ 20'h10000, 1'b0);
      end
      // identification codes, then exit at an arbitrary address
      run(flash_host_pkg::OP_ID_ENTRY, 20'h00000, 8'h00);
      chk("id_mode", 1, id_mode_o);
      rdchk(20'h00000, 1'b1);
      rdchk(20'h00001, 1'b1);
      run(flash_host_pkg::OP_ID_EXIT, 20'($random(seed)), 8'h00);
      chk("id_mode", 0, id_mode_o);
      rdchk(20'h00001, 1'b0);
      // a flash that stays busy past the poll limit, then drains through reads
      busy_reads = 8'd60;
      run(flash_host_pkg::OP_CHIP_ERASE, 20'h00000, 8'h00);
      chk("timeout", 1, timeout_o);
      busy_reads = 8'h02;
      repeat (45) run(flash_host_pkg::OP_READ, a, 8'h00);
      erase_sh(4, a);
      rdchk(a, 1'b0);
      prog(a, 8'h5A);
      rdchk(a, 1'b0);
      chk("host breaches", 0, viol);
      conclude();
   end
endmodule
